// file: hdl/vbm_pkg.sv
// package: constants and state codes of the boot and mode supervisor
// Function
// - both ground-sense straps low select separate mode; either high selects combined
// - combined by first strap uses second ground sense; by second strap uses first
// - straps sampled on reference-ready rise; latch cleared only by shutdown
// - integrator off in pulse-skipping downward moves until settled and comparator edge
// - write-only two-wire link, processor master, 100kHz to 3.4MHz
// - link traffic ignored until system power-ok has gone high
// - while power-good low, clock and data pin levels form boot code
// - three independent 7-bit targets: two core, one northbridge
// - startup ramps targets from zero to boot level, following strap changes
// - at boot level with power-good, boot code is stored; straps then ignored
// - power-ok rise leaves boot mode; targets then set over the link
// - power-ok fall after storing returns all targets to stored boot level
// - boot code clock-high bit: 00 1.1V, 01 1.0V, 10 0.9V, 11 0.8V
// - core offset applied only after boot mode is left
// - option strap at oscillator level or ground enables offset, else disabled
// - enabled core offset present only while power-state bit is high
// - northbridge target always carries fixed 12.5mV offset
// - after boot, power-state 1 forces PWM, 0 selects pulse skipping
// - combined pair: one-phase skipping when bit low, two-phase PWM when high
// - before boot mode ends, all outputs run pulse skipping
package vbm_pkg;
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned SS_STEP_NS    = 12500;  // one 12.5mV code step at 1mV/us
    localparam int unsigned SS_STEP_CYC   = (SS_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [11:0] SS_STEP_CNT   = 12'(SS_STEP_CYC - 1);
    localparam logic [6:0]  VID_ZERO      = 7'h7C;  // code for zero volts
    localparam logic [6:0]  BOOT_VID_00   = 7'h24;  // 1.1V
    localparam logic [6:0]  BOOT_VID_01   = 7'h2C;  // 1.0V
    localparam logic [6:0]  BOOT_VID_10   = 7'h34;  // 0.9V
    localparam logic [6:0]  BOOT_VID_11   = 7'h3C;  // 0.8V
    localparam logic [1:0]  GSEL_OWN      = 2'h0;   // each core its own ground sense
    localparam logic [1:0]  GSEL_FIRST    = 2'h1;
    localparam logic [1:0]  GSEL_SECOND   = 2'h2;
    localparam logic [2:0]  LINK_ADDR_TAG = 3'h6;   // address byte bits 7:5
    localparam logic [4:0]  LINK_ACK1     = 5'h08;  // bit count at address acknowledge
    localparam logic [4:0]  LINK_ACK2     = 5'h11;  // bit count at data acknowledge
    localparam logic [4:0]  LINK_END      = 5'h12;
    localparam int unsigned WORD_SEL_LSB  = 9;      // word bits 9, 10, 11 select core0, core1, nb
    localparam int unsigned WORD_PSI_BIT  = 7;
    typedef enum logic [3:0] {
        ST_OFF    = 4'h1,
        ST_RAMP   = 4'h2,
        ST_STORED = 4'h4,
        ST_SERIAL = 4'h8
    } vbm_state_t;
endpackage

// file: hdl/vbm_link.sv
// write-only serial receiver running on the link clock
`timescale 1ns/1ps
`default_nettype none
module vbm_link
    import vbm_pkg::*;
(
    input  wire logic        vid_serial_clk_i,
    input  wire logic        vid_serial_data_i,
    input  wire logic        rst_n_i,
    input  wire logic        link_en_i,
    output logic             vid_serial_data_o,
    output logic             vid_serial_data_oe_n_o,
    output logic [15:0]      word_o,
    output logic             word_tog_o
);
    logic        start_tog_r;
    logic        start_seen_r;
    logic        en_s1_r;
    logic        en_s2_r;
    logic [4:0]  cnt_r;
    logic [15:0] sh_r;
    logic        match_r;
    logic        ack_r;
    logic        addr_ok;

    // start: data falls while clock is high; any start restarts the frame
    // set against the seen copy, so two starts before one clock rise never cancel
    always_ff @(negedge vid_serial_data_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            start_tog_r <= 1'h0;
        end else if (vid_serial_clk_i) begin
            start_tog_r <= ~start_seen_r;
        end
    end

    // enable level from the system domain; the link clock stops between frames
    always_ff @(posedge vid_serial_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            en_s1_r <= 1'h0;
            en_s2_r <= 1'h0;
        end else begin
            en_s1_r <= link_en_i;
            en_s2_r <= en_s1_r;
        end
    end

    assign addr_ok = (sh_r[7:5] == LINK_ADDR_TAG) && !sh_r[0] && en_s2_r;

    // msb-first shifter: 8 address bits, ack, 8 data bits, ack
    always_ff @(posedge vid_serial_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            start_seen_r <= 1'h0;
            cnt_r        <= 5'h00;
            sh_r         <= 16'h0000;
            match_r      <= 1'h0;
        end else begin
            start_seen_r <= start_tog_r;
            if (start_seen_r != start_tog_r) begin
                cnt_r   <= 5'h01;
                sh_r    <= {15'h0000, vid_serial_data_i};
                match_r <= 1'h0;
            end else if (cnt_r == LINK_ACK1) begin
                cnt_r   <= cnt_r + 5'h01;
                match_r <= addr_ok;
            end else if (cnt_r != 5'h00 && cnt_r < LINK_END) begin
                cnt_r <= cnt_r + 5'h01;
                if (cnt_r != LINK_ACK2) begin
                    sh_r <= {sh_r[14:0], vid_serial_data_i};
                end
            end else begin
                cnt_r <= 5'h00;
            end
        end
    end

    // word and toggle update on the same edge; the word then holds while the toggle crosses, so the far side can sample it
    always_ff @(posedge vid_serial_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            word_o     <= 16'h0000;
            word_tog_o <= 1'h0;
        end else if (cnt_r == LINK_ACK2 && match_r) begin
            word_o     <= sh_r;
            word_tog_o <= ~word_tog_o;
        end
    end

    // acknowledge driven from the falling edge for the whole ack clock
    always_ff @(negedge vid_serial_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_r <= 1'h0;
        end else begin
            ack_r <= (cnt_r == LINK_ACK1 && addr_ok) || (cnt_r == LINK_ACK2 && match_r);
        end
    end

    assign vid_serial_data_o      = 1'h0;
    assign vid_serial_data_oe_n_o = ~ack_r;
endmodule
`default_nettype wire

// file: hdl/vbm_ctrl.sv
// boot, mode-strap and serial target supervisor of the triple regulator controller
`timescale 1ns/1ps
`default_nettype none
module vbm_ctrl
    import vbm_pkg::*;
    #(parameter int unsigned STEP_CYC = SS_STEP_CYC)  // clocks per soft-start code step
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       vid_serial_clk_i,
    input  wire logic       vid_serial_data_i,
    output logic            vid_serial_data_o,
    output logic            vid_serial_data_oe_n_o,
    input  wire logic       shutdown_n_i,
    input  wire logic       reference_ready_i,
    input  wire logic       ground_sense_first_hi_i,
    input  wire logic       ground_sense_second_hi_i,
    input  wire logic       system_power_ok_in_i,
    input  wire logic       output_in_reg_i,
    input  wire logic       option_offset_en_i,
    input  wire logic [2:0] target_settled_i,
    input  wire logic [2:0] err_cmp_i,
    output logic            combined_mode_o,
    output logic [1:0]      gnd_sense_sel_o,
    output logic [6:0]      dac_core0_o,
    output logic [6:0]      dac_core1_o,
    output logic [6:0]      dac_nb_o,
    output logic [1:0]      core_offset_en_o,
    output logic            nb_offset_en_o,
    output logic [2:0]      forced_pwm_o,
    output logic            two_phase_o,
    output logic [2:0]      integ_en_o,
    output logic            power_good_out_o,
    output logic            boot_mode_o
);
    logic [14:0] sync1_r;
    logic [14:0] sync2_r;
    logic        clk_s;
    logic        dat_s;
    logic        shutdown_n_s;
    logic        reference_ready_s;
    logic        gs1_s;
    logic        gs2_s;
    logic        pgin_s;
    logic        inreg_s;
    logic        opt_s;
    logic [2:0]  settled_s;
    logic [2:0]  err_s;

    // every pin passes two flops; first stage feeds only the second
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_r <= 15'h0000;
            sync2_r <= 15'h0000;
        end else begin
            sync1_r <= {vid_serial_clk_i, vid_serial_data_i, shutdown_n_i, reference_ready_i,
                        ground_sense_first_hi_i, ground_sense_second_hi_i,
                        system_power_ok_in_i, output_in_reg_i, option_offset_en_i,
                        target_settled_i, err_cmp_i};
            sync2_r <= sync1_r;
        end
    end
    assign {clk_s, dat_s, shutdown_n_s, reference_ready_s, gs1_s, gs2_s, pgin_s, inreg_s, opt_s,
            settled_s, err_s} = sync2_r;

    logic       reference_ready_d_r;
    logic       mode_valid_r;
    logic       combined_r;
    logic [1:0] gsel_r;
    logic       reference_ready_rise;
    logic       gs_any;
    assign reference_ready_rise = reference_ready_s & ~reference_ready_d_r;
    assign gs_any     = gs1_s | gs2_s;

    // straps are sampled once; hot-swapping a processor needs a shutdown cycle
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reference_ready_d_r    <= 1'h0;
            mode_valid_r <= 1'h0;
            combined_r   <= 1'h0;
            gsel_r       <= GSEL_OWN;
        end else begin
            reference_ready_d_r <= reference_ready_s;
            if (!shutdown_n_s) begin
                mode_valid_r <= 1'h0;
                combined_r   <= 1'h0;
                gsel_r       <= GSEL_OWN;
            end else if (reference_ready_rise && !mode_valid_r) begin
                mode_valid_r <= 1'h1;
                combined_r   <= gs_any;
                gsel_r       <= gs1_s ? GSEL_SECOND : (gs2_s ? GSEL_FIRST : GSEL_OWN);
            end
        end
    end

    logic [15:0] word;
    logic        word_tog;
    logic        link_en_r;
    logic        wt_s1_r;
    logic        wt_s2_r;
    logic        wt_d_r;
    logic        new_word;
    logic        accept;

    vbm_link u_link (
        .vid_serial_clk_i       (vid_serial_clk_i),
        .vid_serial_data_i      (vid_serial_data_i),
        .rst_n_i                (rst_n_i),
        .link_en_i              (link_en_r),
        .vid_serial_data_o      (vid_serial_data_o),
        .vid_serial_data_oe_n_o (vid_serial_data_oe_n_o),
        .word_o                 (word),
        .word_tog_o             (word_tog)
    );

    // toggle handshake; the word itself is stable by the time the toggle arrives
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wt_s1_r <= 1'h0;
            wt_s2_r <= 1'h0;
            wt_d_r  <= 1'h0;
        end else begin
            wt_s1_r <= word_tog;
            wt_s2_r <= wt_s1_r;
            wt_d_r  <= wt_s2_r;
        end
    end
    assign new_word = wt_s2_r ^ wt_d_r;

    vbm_state_t state_r;
    vbm_state_t state_nxt;
    logic [11:0] step_cnt_r;
    logic        step_tick;
    logic [1:0]  boot_code_r;
    logic [1:0]  strap_code;
    logic [6:0]  boot_tgt;
    logic [6:0]  stored_tgt;
    logic        ramp_done;
    logic [6:0]  dac_r [3];
    logic [6:0]  dac_nxt [3];
    logic [2:0]  psi_r;
    logic [2:0]  psi_nxt;
    logic [2:0]  psi_eff;
    logic        serial_nxt;
    logic        pg_r;
    logic [2:0]  fpwm_r;

    function automatic logic [6:0] boot_vid(input logic [1:0] code);
        case (code)
            2'h0:    boot_vid = BOOT_VID_00;
            2'h1:    boot_vid = BOOT_VID_01;
            2'h2:    boot_vid = BOOT_VID_10;
            default: boot_vid = BOOT_VID_11;
        endcase
    endfunction

    assign strap_code = {clk_s, dat_s};
    assign boot_tgt   = boot_vid(strap_code);
    assign stored_tgt = boot_vid(boot_code_r);
    assign ramp_done  = (dac_r[0] == boot_tgt) && (dac_r[1] == boot_tgt) && (dac_r[2] == boot_tgt);
    assign accept     = new_word && (state_r == ST_SERIAL);
    assign step_tick  = (step_cnt_r == 12'h000);

    // soft-start pacing: one code step per tick
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            step_cnt_r <= 12'(STEP_CYC - 1);
        end else if (state_r != ST_RAMP || step_tick) begin
            step_cnt_r <= 12'(STEP_CYC - 1);
        end else begin
            step_cnt_r <= step_cnt_r - 12'h001;
        end
    end

    // sequence: off, ramp to boot, boot stored, serial control
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_OFF:    if (mode_valid_r) state_nxt = ST_RAMP;
            ST_RAMP:   if (ramp_done && inreg_s) state_nxt = ST_STORED;
            ST_STORED: if (pgin_s) state_nxt = ST_SERIAL;
            ST_SERIAL: if (!pgin_s) state_nxt = ST_STORED;
            default:   state_nxt = ST_OFF;
        endcase
        if (!shutdown_n_s) begin
            state_nxt = ST_OFF;
        end
    end

    // target codes; a higher code is a lower voltage
    always_comb begin
        psi_nxt = psi_r;
        for (int k = 0; k < 3; k++) begin
            dac_nxt[k] = dac_r[k];
        end
        if (state_nxt == ST_OFF) begin
            psi_nxt = 3'h0;
            for (int k = 0; k < 3; k++) begin
                dac_nxt[k] = VID_ZERO;
            end
        end else if (state_r == ST_RAMP) begin
            if (step_tick) begin
                for (int k = 0; k < 3; k++) begin
                    if (dac_r[k] > boot_tgt) begin
                        dac_nxt[k] = dac_r[k] - 7'h01;
                    end else if (dac_r[k] < boot_tgt) begin
                        dac_nxt[k] = dac_r[k] + 7'h01;
                    end
                end
            end
        end else if (state_nxt == ST_STORED) begin
            psi_nxt = 3'h0;
            for (int k = 0; k < 3; k++) begin
                dac_nxt[k] = stored_tgt;
            end
        end else if (accept) begin
            for (int k = 0; k < 3; k++) begin
                if (word[WORD_SEL_LSB + k]) begin
                    dac_nxt[k] = word[6:0];
                    psi_nxt[k] = word[WORD_PSI_BIT];
                end
            end
        end
    end

    // state, codes and power-state bits
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= ST_OFF;
            psi_r   <= 3'h0;
            for (int k = 0; k < 3; k++) begin
                dac_r[k] <= VID_ZERO;
            end
        end else begin
            state_r <= state_nxt;
            psi_r   <= psi_nxt;
            for (int k = 0; k < 3; k++) begin
                dac_r[k] <= dac_nxt[k];
            end
        end
    end

    // boot code stored with power-good; straps ignored afterwards
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pg_r        <= 1'h0;
            boot_code_r <= 2'h0;
            link_en_r   <= 1'h0;
        end else begin
            link_en_r <= (state_r == ST_SERIAL);
            if (!shutdown_n_s) begin
                pg_r <= 1'h0;
            end else if (state_r == ST_RAMP && state_nxt == ST_STORED) begin
                pg_r        <= 1'h1;
                boot_code_r <= strap_code;
            end
        end
    end

    logic       two_phase_r;
    logic [1:0] core_off_r;
    logic       nb_off_r;
    logic       boot_mode_r;

    assign serial_nxt = (state_nxt == ST_SERIAL);
    // combined pair follows the first core's bit
    assign psi_eff = {psi_nxt[2], combined_r ? psi_nxt[0] : psi_nxt[1], psi_nxt[0]};

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fpwm_r      <= 3'h0;
            two_phase_r <= 1'h0;
            core_off_r  <= 2'h0;
            nb_off_r    <= 1'h1;
            boot_mode_r <= 1'h1;
        end else begin
            fpwm_r      <= serial_nxt ? psi_eff : 3'h0;
            two_phase_r <= serial_nxt && combined_r && psi_nxt[0];
            core_off_r  <= (serial_nxt && !opt_s) ? psi_eff[1:0] : 2'h0;
            nb_off_r    <= 1'h1;
            boot_mode_r <= !serial_nxt;
        end
    end

    logic [2:0] err_d_r;
    logic [2:0] err_edge;
    logic [2:0] down_pskip;
    logic [2:0] integ_off_r;
    assign err_edge = err_s ^ err_d_r;
    always_comb begin
        for (int k = 0; k < 3; k++) begin
            down_pskip[k] = (dac_nxt[k] > dac_r[k]) && !fpwm_r[k];
        end
    end

    // a new downward step wins over a release in the same cycle
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            err_d_r     <= 3'h0;
            integ_off_r <= 3'h0;
        end else begin
            err_d_r <= err_s;
            for (int k = 0; k < 3; k++) begin
                if (down_pskip[k]) begin
                    integ_off_r[k] <= 1'h1;
                end else if (settled_s[k] && err_edge[k]) begin
                    integ_off_r[k] <= 1'h0;
                end
            end
        end
    end

    // registered outputs to the analog loops
    assign combined_mode_o  = combined_r;
    assign gnd_sense_sel_o  = gsel_r;
    assign dac_core0_o      = dac_r[0];
    assign dac_core1_o      = dac_r[1];
    assign dac_nb_o         = dac_r[2];
    assign core_offset_en_o = core_off_r;
    assign nb_offset_en_o   = nb_off_r;
    assign forced_pwm_o     = fpwm_r;
    assign two_phase_o      = two_phase_r;
    assign integ_en_o       = ~integ_off_r;
    assign power_good_out_o = pg_r;
    assign boot_mode_o      = boot_mode_r;

    chk_mode_latch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (reference_ready_rise && shutdown_n_s && !mode_valid_r) |=> (combined_mode_o == $past(gs_any)))
        else $error("combined mode not taken from straps");
    chk_gnd_route: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (reference_ready_rise && shutdown_n_s && !mode_valid_r && !gs1_s && gs2_s) |=>
        (gnd_sense_sel_o == GSEL_FIRST))
        else $error("ground sense not routed to first input");
    chk_mode_keep: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (mode_valid_r && shutdown_n_s) |=> ($stable(combined_mode_o) && $stable(gnd_sense_sel_o)))
        else $error("mode latch changed without shutdown");
    chk_integ_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (integ_off_r[0] && !(settled_s[0] && err_edge[0])) |=> !integ_en_o[0])
        else $error("integrator released early");
    chk_link_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (new_word && state_r != ST_SERIAL) |=> $stable(psi_r))
        else $error("link word taken before power-ok");
    chk_ramp_pace: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_r == ST_RAMP && !step_tick && shutdown_n_s) |=> $stable(dac_core0_o))
        else $error("ramp stepped off its pace");
    chk_boot_store: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_r == ST_RAMP && ramp_done && inreg_s && shutdown_n_s) |=>
        (power_good_out_o && boot_code_r == $past(strap_code) && state_r == ST_STORED))
        else $error("boot code not stored");
    chk_boot_return: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_r == ST_SERIAL && !pgin_s && shutdown_n_s) |=>
        (dac_core0_o == stored_tgt && dac_nb_o == stored_tgt))
        else $error("targets not returned to boot level");
    chk_offset_boot: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_r != ST_SERIAL) |-> (core_offset_en_o == 2'h0))
        else $error("core offset during boot mode");
    chk_pskip_boot: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_r != ST_SERIAL) |-> (forced_pwm_o == 3'h0 && !two_phase_o))
        else $error("forced pwm during boot mode");
    cov_serial: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        state_r == ST_STORED ##1 state_r == ST_SERIAL);
    cov_return: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        state_r == ST_SERIAL ##1 state_r == ST_STORED);
    cov_integ: cover property (@(posedge clk_i) disable iff (!rst_n_i) down_pskip[0]);
    cov_combined: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        combined_mode_o && accept);
endmodule
`default_nettype wire

// file: testbench/vbm_host_model.sv
// processor-side master model of the write-only voltage-id link
`timescale 1ns/1ps
`default_nettype none
module vbm_host_model (
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    // link clock stands high between frames; data released to the pull-up
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // static strap levels on both pins while power-good is still low
    task automatic strap(input logic c, input logic d);
        scl_o = c;
        sda_o = d;
    endtask
    // data moves only while the clock is low, well clear of the falling edge
    task automatic bit_io(input logic b, output logic s);
        scl_o = 1'b0;
        #5 sda_o = b;
        #10 scl_o = 1'b1;
        s = sda_i;
        #15;
    endtask
    // start, address, ack, data, ack, stop; master owns the clock
    task automatic send(input logic [7:0] a, input logic [7:0] d, output logic ack);
        logic s;
        ack = 1'b1;
        sda_o = 1'b0;
        #15;
        for (int i = 0; i < 18; i++) begin
            bit_io((i == 8 || i == 17) ? 1'b1 : ((i < 8) ? a[7-i] : d[16-i]), s);
            if (i == 8 || i == 17) ack = ack & ~s;
        end
        bit_io(1'b0, s);
        #5 sda_o = 1'b1;
    endtask
endmodule
`default_nettype wire

// file: testbench/vbm_ctrl_bench.sv
// self-checking bench of the boot and mode supervisor
`timescale 1ns/1ps
`default_nettype none
module vbm_ctrl_bench;
    import vbm_pkg::*;
    logic clk_i = 1'b0, rst_n_i = 1'b0, shutdown_n_n = 1'b0, ref_rdy = 1'b0;
    logic gs1 = 1'b0, gs2 = 1'b0, pok = 1'b0, ack;
    logic inreg = 1'b0, opt = 1'b0;
    logic [2:0] settled = 3'h0, err = 3'h0;
    localparam int unsigned STEP = 250;  // shortened ramp pace keeps the run brief
    wire logic scl, sda_m, sda_d, oe_n, sda;
    logic [6:0] d0, d1, dn;
    logic [1:0] coff, gsel;
    logic [2:0] fpwm, integ;
    logic comb, nboff, tph, pgood, bootm;
    int failures = 0, num_checks = 0, cycles = 0;
    // open-drain data line: pull-up unless someone pulls low
    assign sda = sda_m & (oe_n | sda_d);
    vbm_host_model host (.sda_i(sda), .scl_o(scl), .sda_o(sda_m));
    vbm_ctrl #(.STEP_CYC(STEP)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .vid_serial_clk_i(scl),
        .vid_serial_data_i(sda), .vid_serial_data_o(sda_d), .vid_serial_data_oe_n_o(oe_n),
        .shutdown_n_i(shutdown_n_n), .reference_ready_i(ref_rdy), .ground_sense_first_hi_i(gs1),
        .ground_sense_second_hi_i(gs2), .system_power_ok_in_i(pok), .output_in_reg_i(inreg),
        .option_offset_en_i(opt), .target_settled_i(settled), .err_cmp_i(err),
        .combined_mode_o(comb), .gnd_sense_sel_o(gsel), .dac_core0_o(d0), .dac_core1_o(d1),
        .dac_nb_o(dn), .core_offset_en_o(coff), .nb_offset_en_o(nboff), .forced_pwm_o(fpwm),
        .two_phase_o(tph), .integ_en_o(integ), .power_good_out_o(pgood), .boot_mode_o(bootm));
    always #2.5 clk_i = ~clk_i;
    // the shortened ramp takes about 18k cycles; the ceiling leaves margin
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 25000) begin
            failures++;
            print_verdict();
        end
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic print_verdict();
        if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // strap latch: first strap high, then a second reference edge is ignored
    task automatic t_straps();
        shutdown_n_n = 1'b1;
        gs1 = 1'b1;
        wait_clk(3);
        ref_rdy = 1'b1;
        wait_clk(6);
        chk("comb", 8'h01, comb);
        chk("gsel", 8'h02, gsel);
        gs1 = 1'b0;
        gs2 = 1'b1;
        ref_rdy = 1'b0;
        wait_clk(4);
        ref_rdy = 1'b1;
        wait_clk(6);
        chk("gsel_held", 8'(GSEL_SECOND), gsel);
        shutdown_n_n = 1'b0;
        ref_rdy = 1'b0;
        wait_clk(4);
        chk("mode_clr", 8'h00, comb);
        shutdown_n_n = 1'b1;
        wait_clk(3);
        ref_rdy = 1'b1;
        wait_clk(6);
        chk("comb_2", 8'h01, comb);
        chk("gsel_first", 8'(GSEL_FIRST), gsel);
    endtask
    // soft-start toward code 11, straps moved to 10 mid-ramp, stored late, link deaf
    task automatic t_boot();
        wait_clk(300);
        chk("ramp_step", 8'(VID_ZERO - 7'h01), d0);
        host.strap(1'b1, 1'b0);
        for (int i = 0; i < 20000 && d0 !== BOOT_VID_10; i++) wait_clk(1);
        wait_clk(5);
        chk("pg_early", 8'h00, pgood);
        inreg = 1'b1;
        wait_clk(5);
        chk("pg_store", 8'h01, pgood);
        host.strap(1'b1, 1'b1);
        wait_clk(5);
        chk("boot_c1", 8'(BOOT_VID_10), d1);
        chk("boot_nb", 8'(BOOT_VID_10), dn);
        chk("boot_pwm", 8'h00, fpwm);
        host.send(8'hC2, 8'hB0, ack);
        wait_clk(20);
        chk("early_ack", 8'h00, ack);
        chk("early_c0", 8'(BOOT_VID_10), d0);
        chk("boot_off", 8'h00, coff);
    endtask
    // serial mode: core0 high power state, option off, then core0 and nb skipping
    task automatic t_serial();
        pok = 1'b1;
        wait_clk(10);
        chk("boot_mode", 8'h00, bootm);
        host.send(8'hC2, 8'hB0, ack);
        wait_clk(20);
        chk("ack", 8'h01, ack);
        chk("c0", 8'h30, d0);
        chk("c1", 8'(BOOT_VID_10), d1);
        chk("pwm0", 8'h01, fpwm[0]);
        chk("two_ph", 8'h01, tph);
        chk("c0_off", 8'h01, coff[0]);
        opt = 1'b1;
        wait_clk(5);
        chk("opt_off", 8'h00, coff);
        host.send(8'hCA, 8'h28, ack);
        wait_clk(20);
        chk("nb", 8'h28, dn);
        chk("c0_skip", 8'h28, d0);
        chk("pwm_nb", 8'h00, fpwm);
        chk("nb_off", 8'h01, nboff);
        pok = 1'b0;
        wait_clk(10);
        chk("ret_c0", 8'(BOOT_VID_10), d0);
        chk("ret_nb", 8'(BOOT_VID_10), dn);
        chk("integ_nb", 8'h02, integ);
        settled = 3'h7;
        err = 3'h7;
        wait_clk(5);
        chk("integ_on", 8'h07, integ);
    endtask
    initial begin
        wait_clk(5);
        chk("rst_dac", 8'(VID_ZERO), d0);
        chk("rst_boot", 8'h01, bootm);
        rst_n_i = 1'b1;
        t_straps();
        t_boot();
        t_serial();
        print_verdict();
    end
endmodule
`default_nettype wire
